// ===== rtl/spi_eeprom_front.sv
// Serial slave front end of a byte-addressed nonvolatile memory.
// Assumes mclk oversamples the serial clock at least eight times.
`timescale 1ns/1ps
module spi_eeprom_front
   import spi_eeprom_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYC_DEF
)(
   input  wire logic      mclk,
   input  wire logic      reset,
   input  wire spi_pins_t pins,
   output logic           so,
   output logic           so_oe,
   output logic           standby
);

   if (WRITE_CYC < WRITE_CYC_MIN)
   begin : g_bad_write_cyc
      $error("WRITE_CYC too short to commit a page");
   end

   localparam int TW = $clog2(WRITE_CYC + 1);
   localparam logic [TW-1:0] TMR_LAST = TW'(WRITE_CYC - 1);

   function automatic logic op_valid(input logic [7:0] op);
      op_valid = (op == OP_WRSR) || (op == OP_WRITE) || (op == OP_READ) ||
                 (op == OP_WRDI) || (op == OP_RDSR) || (op == OP_WREN) ||
                 (op == OP_WRID) || (op == OP_RDID);
   endfunction

   function automatic logic prot_hit(input logic [12:0] a, input logic [1:0] bp);
      unique case (bp)
         BP_NONE: prot_hit = 1'b0;
         BP_QTR:  prot_hit = (a >= QTR_BASE);
         BP_HALF: prot_hit = (a >= HALF_BASE);
         BP_ALL:  prot_hit = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second
   spi_pins_t pins_q1_r;
   spi_pins_t pins_q2_r;
   spi_pins_t pins_q3_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         pins_q1_r <= PINS_IDLE;
         pins_q2_r <= PINS_IDLE;
         pins_q3_r <= PINS_IDLE;
      end
      else
      begin
         pins_q1_r <= pins;
         pins_q2_r <= pins_q1_r;
         pins_q3_r <= pins_q2_r;
      end
   end

   logic sel;
   logic act;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;

   assign sel     = !pins_q2_r.cs_n;
   assign act     = sel && pins_q2_r.hold_n;
   // Only edges while selected count, so the idle level never matters
   assign rise    = act && pins_q2_r.sck && !pins_q3_r.sck;
   assign fall    = act && !pins_q2_r.sck && pins_q3_r.sck;
   assign cs_rise = pins_q2_r.cs_n && !pins_q3_r.cs_n;
   assign cs_fall = !pins_q2_r.cs_n && pins_q3_r.cs_n;

   ////////////////////////////////////////////////////////////////////////////
   // Frame state
   logic [2:0]        bit_r, bit_nxt;
   logic [1:0]        byte_r, byte_nxt;
   logic [7:0]        sh_r, sh_nxt;
   logic [7:0]        op_r, op_nxt;
   logic              op_ok_r, op_ok_nxt;
   logic [ARR_AW-1:0] addr_r, addr_nxt;
   logic              lock_req_r, lock_req_nxt;
   logic [7:0]        sr_data_r, sr_data_nxt;
   logic              sr_got_r, sr_got_nxt;
   logic              wdone_r, wdone_nxt;
   logic [31:0]       mask_r, mask_nxt;
   logic [7:0]        out_r, out_nxt;
   logic              oe_r, oe_nxt;
   logic              pbuf_we;

   logic              wen_r, wen_nxt;
   logic [1:0]        bp_r, bp_nxt;
   logic              wpen_r, wpen_nxt;
   logic              lock_r, lock_nxt;
   wr_state_t         st_r, st_nxt;
   logic [5:0]        idx_r, idx_nxt;
   logic [TW-1:0]     tmr_r, tmr_nxt;
   logic [MEM_AW-1:0] base_r, base_nxt;
   logic              start;

   logic [7:0]        bin;
   logic              bdone;
   logic              busy;
   logic              is_id;
   logic              rd_op;
   logic              wr_op;
   logic              out_ph;
   logic [7:0]        sr_view;
   logic [ARR_AW-1:0] rd_next;
   logic [MEM_AW-1:0] mem_addr;
   logic              mem_we;
   logic [7:0]        mem_rdata;
   logic [7:0]        pbuf_rdata;
   logic [4:0]        cidx;

   assign bin     = {sh_r[6:0], pins_q2_r.si};
   assign bdone   = rise && (bit_r == 3'h7);
   assign busy    = (st_r != ST_IDLE);
   assign is_id   = (op_r == OP_RDID) || (op_r == OP_WRID);
   assign rd_op   = (op_r == OP_READ) || (op_r == OP_RDID);
   assign wr_op   = (op_r == OP_WRITE) || (op_r == OP_WRID);
   assign out_ph  = op_ok_r && (((op_r == OP_RDSR) && (byte_r != 2'h0)) ||
                                (rd_op && (byte_r == 2'h3)));
   // Status bits read as all ones during an internal write
   assign sr_view = busy ? SR_BUSY_VIEW :
                    {wpen_r, 3'h0, bp_r, wen_r, 1'b0};
   assign rd_next = is_id ? {addr_r[12:5], addr_r[4:0] + 5'h01} : addr_r + 13'h0001;

   always_comb
   begin
      bit_nxt      = bit_r;
      byte_nxt     = byte_r;
      sh_nxt       = sh_r;
      op_nxt       = op_r;
      op_ok_nxt    = op_ok_r;
      addr_nxt     = addr_r;
      lock_req_nxt = lock_req_r;
      sr_data_nxt  = sr_data_r;
      sr_got_nxt   = sr_got_r;
      wdone_nxt    = wdone_r;
      mask_nxt     = mask_r;
      out_nxt      = out_r;
      // Enable survives a pause, so the output returns with the resume
      oe_nxt       = oe_r && sel;
      pbuf_we      = 1'b0;
      if (!sel)
      begin
         bit_nxt      = 3'h0;
         byte_nxt     = 2'h0;
         op_ok_nxt    = 1'b0;
         sr_got_nxt   = 1'b0;
         wdone_nxt    = 1'b0;
         lock_req_nxt = 1'b0;
      end
      else if (rise)
      begin
         sh_nxt  = bin;
         bit_nxt = bit_r + 3'h1;
         if (bit_r == 3'h7)
         begin
            if (byte_r != 2'h3)
               byte_nxt = byte_r + 2'h1;
            unique case (byte_r)
               2'h0:
               begin
                  op_nxt    = bin;
                  op_ok_nxt = op_valid(bin) && (!busy || bin == OP_RDSR);
               end
               2'h1:
               begin
                  sr_data_nxt    = bin;
                  sr_got_nxt     = 1'b1;
                  addr_nxt[12:8] = bin[4:0];
                  lock_req_nxt   = bin[LOCK_BIT];
               end
               2'h2: addr_nxt[7:0] = bin;
               2'h3:
               begin
                  if (op_ok_r && wr_op)
                  begin
                     pbuf_we              = 1'b1;
                     mask_nxt[addr_r[4:0]] = 1'b1;
                     addr_nxt[4:0]        = addr_r[4:0] + 5'h01;
                     wdone_nxt            = 1'b1;
                  end
               end
            endcase
         end
      end
      else if (fall && out_ph)
      begin
         oe_nxt = 1'b1;
         if (bit_r == 3'h0)
         begin
            out_nxt = (op_r == OP_RDSR) ? sr_view : mem_rdata;
            if (rd_op)
               addr_nxt = rd_next;
         end
         else
            out_nxt = {out_r[6:0], 1'b0};
      end
      // Never cleared under a running commit, which still reads the mask
      if ((cs_fall && !busy) || (st_r == ST_WAIT))
         mask_nxt = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status bits and self-timed write
   logic clean;
   logic hw_prot;

   // Ending mid-byte drops the instruction
   assign clean   = cs_rise && op_ok_r && (bit_r == 3'h0);
   assign hw_prot = wpen_r && !pins_q2_r.wp_n;
   assign cidx    = 5'(idx_r - 6'h01);

   always_comb
   begin
      wen_nxt  = wen_r;
      bp_nxt   = bp_r;
      wpen_nxt = wpen_r;
      lock_nxt = lock_r;
      st_nxt   = st_r;
      idx_nxt  = idx_r;
      tmr_nxt  = tmr_r;
      base_nxt = base_r;
      start    = 1'b0;
      if (clean && !busy)
      begin
         if (op_r == OP_WREN)
            wen_nxt = 1'b1;
         else if (op_r == OP_WRDI)
            wen_nxt = 1'b0;
         else if (op_r == OP_WRSR && sr_got_r && wen_r && !hw_prot)
         begin
            bp_nxt   = sr_data_r[SR_BP1:SR_BP0];
            wpen_nxt = sr_data_r[SR_WPEN];
            base_nxt = ARR_BASE;
            start    = 1'b1;
         end
         else if (wr_op && wdone_r && wen_r && is_id && !lock_r)
         begin
            lock_nxt = lock_req_r;
            base_nxt = ID_BASE;
            start    = 1'b1;
         end
         else if (wr_op && wdone_r && wen_r && !is_id &&
                  !prot_hit({addr_r[12:5], 5'h00}, bp_r))
         begin
            base_nxt = {1'b0, addr_r[12:5], 5'h00};
            start    = 1'b1;
         end
      end
      unique case (st_r)
         ST_IDLE:
         begin
            if (start)
            begin
               wen_nxt = 1'b0;
               st_nxt  = ST_COMMIT;
               idx_nxt = 6'h00;
               tmr_nxt = '0;
            end
         end
         ST_COMMIT:
         begin
            tmr_nxt = tmr_r + 1'b1;
            idx_nxt = idx_r + 6'h01;
            if (idx_r == COMMIT_LAST)
               st_nxt = ST_WAIT;
         end
         ST_WAIT:
         begin
            tmr_nxt = tmr_r + 1'b1;
            if (tmr_r == TMR_LAST)
               st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         bit_r      <= 3'h0;
         byte_r     <= 2'h0;
         sh_r       <= 8'h00;
         op_r       <= 8'h00;
         op_ok_r    <= 1'b0;
         addr_r     <= 13'h0000;
         lock_req_r <= 1'b0;
         sr_data_r  <= 8'h00;
         sr_got_r   <= 1'b0;
         wdone_r    <= 1'b0;
         mask_r     <= 32'h0000_0000;
         out_r      <= 8'h00;
         oe_r       <= 1'b0;
         wen_r      <= RST_WEN;
         bp_r       <= RST_BP;
         wpen_r     <= RST_WPEN;
         lock_r     <= RST_LOCK;
         st_r       <= ST_IDLE;
         idx_r      <= 6'h00;
         tmr_r      <= '0;
         base_r     <= ARR_BASE;
      end
      else
      begin
         bit_r      <= bit_nxt;
         byte_r     <= byte_nxt;
         sh_r       <= sh_nxt;
         op_r       <= op_nxt;
         op_ok_r    <= op_ok_nxt;
         addr_r     <= addr_nxt;
         lock_req_r <= lock_req_nxt;
         sr_data_r  <= sr_data_nxt;
         sr_got_r   <= sr_got_nxt;
         wdone_r    <= wdone_nxt;
         mask_r     <= mask_nxt;
         out_r      <= out_nxt;
         oe_r       <= oe_nxt;
         wen_r      <= wen_nxt;
         bp_r       <= bp_nxt;
         wpen_r     <= wpen_nxt;
         lock_r     <= lock_nxt;
         st_r       <= st_nxt;
         idx_r      <= idx_nxt;
         tmr_r      <= tmr_nxt;
         base_r     <= base_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array and page buffer; masked bytes only, so partial pages keep the rest
   assign mem_we   = (st_r == ST_COMMIT) && (idx_r != 6'h00) && mask_r[cidx];
   assign mem_addr = (st_r == ST_COMMIT) ? (base_r | {9'h000, cidx}) :
                     is_id ? (ID_BASE | {9'h000, addr_r[4:0]}) : {1'b0, addr_r};

   byte_ram #(.DEPTH(MEM_DEPTH), .AW(MEM_AW), .DW(8)) u_array (
      .mclk  (mclk),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (pbuf_rdata),
      .rdata (mem_rdata)
   );

   byte_ram #(.DEPTH(PAGE_BYTES), .AW(PAGE_AW), .DW(8)) u_page_buf (
      .mclk  (mclk),
      .we    (pbuf_we),
      .addr  ((st_r == ST_COMMIT) ? idx_r[4:0] : addr_r[4:0]),
      .wdata (bin),
      .rdata (pbuf_rdata)
   );

   assign so      = out_r[7];
   assign so_oe   = oe_r && act;
   assign standby = !sel && !busy;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_standby_quiet: assert property (
      pins_q2_r.cs_n |-> !so_oe) else $error("Output driven while deselected");
   a_hold_freeze: assert property (
      sel && !pins_q2_r.hold_n |-> !so_oe ##1 $stable(bit_r))
      else $error("Transfer moved during pause");
   a_deselect_clear: assert property (
      !sel |=> bit_r == 3'h0 && byte_r == 2'h0 && !op_ok_r)
      else $error("Shift state not reset while deselected");
   a_msb_shift: assert property (
      rise |=> sh_r[0] == $past(pins_q2_r.si) && sh_r[7:1] == $past(sh_r[6:0]))
      else $error("Input not shifted msb first");
   a_busy_only_status: assert property (
      bdone && byte_r == 2'h0 && busy && bin != OP_RDSR |=> !op_ok_r)
      else $error("Instruction accepted while busy");
   a_write_start: assert property (
      start |=> st_r == ST_COMMIT && !wen_r ##33 st_r == ST_WAIT)
      else $error("Internal write did not start on select rise");
   a_write_bound: assert property (
      st_r == ST_WAIT && tmr_r == TMR_LAST |=> st_r == ST_IDLE && standby == !sel)
      else $error("Internal write overran its time");
   a_protect_block: assert property (
      mem_we && !mem_addr[13] |-> !prot_hit(mem_addr[12:0], bp_r))
      else $error("Write into protected block");
   a_id_locked: assert property (
      start && lock_r |-> !base_nxt[13]) else $error("Locked page written");
   a_page_wrap: assert property (
      pbuf_we && addr_r[4:0] == 5'h1f |=> addr_r[4:0] == 5'h00 && $stable(addr_r[12:5]))
      else $error("Page address left its page");
   a_reset_standby: assert property (
      @(posedge mclk) disable iff (1'b0)
      reset |=> st_r == ST_IDLE && !wen_r && !so_oe && !op_ok_r)
      else $error("Reset did not enter standby");

   c_read_out: cover property (fall && out_ph && bit_r == 3'h0 && op_r == OP_READ);
   c_page_commit: cover property (start && wr_op ##1 st_r == ST_COMMIT);
   c_pause_resume: cover property (sel && !pins_q2_r.hold_n ##1 act);
   c_write_done: cover property (st_r == ST_WAIT ##1 st_r == ST_IDLE);

endmodule

// ===== rtl/spi_eeprom_pkg.sv
// Constants, opcodes and types for the serial memory front end.
// Assumes one system clock that oversamples every link pin.
package spi_eeprom_pkg;

   localparam int ARRAY_BYTES = 8192;
   localparam int PAGE_BYTES  = 32;
   localparam int ID_BYTES    = 32;
   localparam int MEM_DEPTH   = ARRAY_BYTES + ID_BYTES;
   localparam int MEM_AW      = 14;
   localparam int ARR_AW      = 13;
   localparam int PAGE_AW     = 5;

   localparam int CLK_MHZ       = 100;
   localparam int WRITE_MS      = 4;
   // Longest time, rounded down to whole cycles
   localparam int WRITE_CYC_DEF = WRITE_MS * 1000 * CLK_MHZ;
   localparam int WRITE_CYC_MIN = 64;

   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRID = 8'h82;
   localparam logic [7:0] OP_RDID = 8'h83;

   localparam int SR_WEN  = 1;
   localparam int SR_BP0  = 2;
   localparam int SR_BP1  = 3;
   localparam int SR_WPEN = 7;
   localparam logic [7:0] SR_BUSY_VIEW = 8'hff;

   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QTR  = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL  = 2'h3;
   localparam logic [12:0] QTR_BASE  = 13'h1800;
   localparam logic [12:0] HALF_BASE = 13'h1000;

   localparam int LOCK_BIT = 2;
   localparam logic [MEM_AW-1:0] ID_BASE  = 14'h2000;
   localparam logic [MEM_AW-1:0] ARR_BASE = 14'h0000;
   localparam logic [5:0] COMMIT_LAST = 6'h20;

   localparam logic       RST_WEN  = 1'b0;
   localparam logic [1:0] RST_BP   = 2'h0;
   localparam logic       RST_WPEN = 1'b0;
   localparam logic       RST_LOCK = 1'b0;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
      logic wp_n;
   } spi_pins_t;

   localparam spi_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                       hold_n: 1'b1, wp_n: 1'b1};

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_COMMIT = 3'b010,
      ST_WAIT   = 3'b100
   } wr_state_t;

endpackage

// ===== rtl/byte_ram.sv
// Single-port byte memory with registered read data.
// Assumes the caller keeps addresses below DEPTH.
`timescale 1ns/1ps
module byte_ram
   import spi_eeprom_pkg::*;
#(
   parameter int DEPTH = MEM_DEPTH,
   parameter int AW    = MEM_AW,
   parameter int DW    = 8
)(
   input  wire logic          mclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);

   if (DEPTH < 1 || DEPTH > (1 << AW))
   begin : g_bad_depth
      $error("byte_ram depth does not fit address width");
   end

   logic [DW-1:0] mem [DEPTH];

   // No reset on contents: the array instance is the nonvolatile store
   always_ff @(posedge mclk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end

endmodule

// ===== testbench/spi_master_model.sv
// Bus master model that drives the memory's link pins.
// Assumes one caller; all pins change 1 ns after an mclk edge.
`timescale 1ns/1ps
module spi_master_model
   import spi_eeprom_pkg::*;
(
   input  wire logic mclk,
   input  wire logic so,
   input  wire logic so_oe,
   output spi_pins_t pins
);
   logic mode3;

   initial
   begin
      mode3 = 1'b0;
      pins  = PINS_IDLE;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Clock parks at its idle level before select falls
   task automatic start();
      pins.sck  = mode3;
      tick(4);
      pins.cs_n = 1'b0;
      tick(6);
   endtask

   // Halves of 6 and 6 or 7 cycles average a 125 ns link period
   task automatic xfer(input logic [7:0] tx, input int top, input int nb,
                       output logic [7:0] rx);
      for (int i = top; i > top - nb; i--)
      begin
         pins.sck = 1'b0;
         pins.si  = tx[i];
         tick(6);
         pins.sck = 1'b1;
         // An undriven output reads as the inverse, so a missing enable shows
         rx[i]    = so_oe ? so : ~so;
         tick(6 + i % 2);
      end
   endtask

   task automatic stop();
      if (!mode3)
         pins.sck = 1'b0;
      tick(3);
      pins.cs_n = 1'b1;
      // A released line must not keep showing its last bit
      pins.si   = ~pins.si;
      tick(6);
   endtask

   task automatic pause(input int n, output logic oe_seen);
      pins.sck    = 1'b0;
      tick(6);
      pins.hold_n = 1'b0;
      tick(n);
      oe_seen     = so_oe;
      pins.hold_n = 1'b1;
      tick(6);
   endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the serial memory front end.
// Assumes the master model above is the only driver of the link pins.
`timescale 1ns/1ps
module testbench
   import spi_eeprom_pkg::*;
;
   // Long enough that a status poll and a refused enable both land while busy
   localparam int WCYC = 600;

   logic       mclk;
   logic       reset;
   spi_pins_t  pins;
   logic       so;
   logic       so_oe;
   logic       standby;
   logic [7:0] rd;
   logic       oe;
   int         miscompares;
   int         n_compared;

   spi_eeprom_front #(.WRITE_CYC(WCYC)) dut (
      .mclk    (mclk),
      .reset   (reset),
      .pins    (pins),
      .so      (so),
      .so_oe   (so_oe),
      .standby (standby)
   );

   spi_master_model m (
      .mclk  (mclk),
      .so    (so),
      .so_oe (so_oe),
      .pins  (pins)
   );

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Counts: %0d mismatches in %0d comparisons", miscompares, n_compared);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic bx(input logic [7:0] tx);
      m.xfer(tx, 7, 8, rd);
   endtask

   task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n);
      m.start();
      bx(op);
      repeat (n) bx(arg);
      m.stop();
   endtask

   task automatic status(input logic [7:0] exp);
      cmd(OP_RDSR, 8'h00, 1);
      check(rd, exp, "status");
   endtask

   // Bounded wait: a write that never ends closes the run
   task automatic wait_idle();
      int n;
      n = 0;
      while (standby !== 1'b1 && n < WCYC + 100)
      begin
         m.tick(1);
         n++;
      end
      check({7'h0, standby}, 8'h01, "write end");
      if (n >= WCYC + 100)
         conclude();
   endtask

   task automatic wr_any(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo,
                         input logic [7:0] d[$]);
      cmd(OP_WREN, 8'h00, 0);
      m.start();
      bx(op);
      bx(hi);
      bx(lo);
      foreach (d[i]) bx(d[i]);
      m.stop();
   endtask

   task automatic wr_mem(input logic [12:0] a, input logic [7:0] d[$]);
      wr_any(OP_WRITE, {3'h0, a[12:8]}, a[7:0], d);
   endtask

   task automatic rd_any(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo,
                         input logic [7:0] exp[$]);
      m.start();
      bx(op);
      bx(hi);
      bx(lo);
      foreach (exp[i])
      begin
         bx(8'h00);
         check(rd, exp[i], "read data");
      end
      m.stop();
   endtask

   task automatic rd_mem(input logic [12:0] a, input logic [7:0] exp[$]);
      rd_any(OP_READ, {3'h0, a[12:8]}, a[7:0], exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_status();
      m.mode3 = 1'b0;
      cmd(OP_WREN, 8'h00, 0);
      status(8'h02);
      check({7'h0, so_oe}, 8'h00, "output released");
      m.start();
      bx(8'ha5);
      bx(8'h00);
      check({7'h0, so_oe}, 8'h00, "undefined code silent");
      m.stop();
      cmd(OP_WRDI, 8'h00, 0);
      status(8'h00);
   endtask

   task automatic s_write();
      m.mode3 = 1'b1;
      wr_mem(13'h0040, {8'h11, 8'h22, 8'h33, 8'h44});
      check({7'h0, standby}, 8'h00, "busy after select");
      status(SR_BUSY_VIEW);
      cmd(OP_WREN, 8'h00, 0);
      wait_idle();
      status(8'h00);
      wr_mem(13'h0041, {8'h5a});
      wait_idle();
      rd_mem(13'h0040, {8'h11, 8'h5a, 8'h33, 8'h44});
      // Page write wraps inside its page
      wr_mem(13'h005f, {8'ha1, 8'hb2});
      wait_idle();
      rd_mem(13'h0040, {8'hb2});
   endtask

   task automatic s_protect();
      m.mode3 = 1'b0;
      wr_mem(13'h1800, {8'hc3});
      wait_idle();
      cmd(OP_WREN, 8'h00, 0);
      cmd(OP_WRSR, 8'h04, 1);
      wait_idle();
      status(8'h04);
      wr_mem(13'h1800, {8'h3c});
      wait_idle();
      wr_mem(13'h17ff, {8'hd4});
      wait_idle();
      rd_mem(13'h17ff, {8'hd4, 8'hc3});
      // Status is locked while its protect-enable bit is set and the pin is low
      cmd(OP_WREN, 8'h00, 0);
      cmd(OP_WRSR, 8'h84, 1);
      wait_idle();
      m.pins.wp_n = 1'b0;
      cmd(OP_WREN, 8'h00, 0);
      cmd(OP_WRSR, 8'h00, 1);
      wait_idle();
      status(8'h86);
      m.pins.wp_n = 1'b1;
      cmd(OP_WRSR, 8'h00, 1);
      wait_idle();
      status(8'h00);
   endtask

   task automatic s_misalign();
      m.mode3 = 1'b1;
      cmd(OP_WREN, 8'h00, 0);
      m.start();
      bx(OP_WRITE);
      bx(8'h00);
      bx(8'h42);
      m.xfer(8'h77, 7, 5, rd);
      m.stop();
      check({7'h0, standby}, 8'h01, "no write started");
      rd_mem(13'h0042, {8'h33});
   endtask

   task automatic s_pause();
      logic [7:0] hi;
      m.mode3 = 1'b1;
      m.start();
      bx(OP_READ);
      bx(8'h00);
      bx(8'h43);
      m.xfer(8'h00, 7, 4, hi);
      m.pause(20, oe);
      check({7'h0, oe}, 8'h00, "output off in pause");
      check({7'h0, so_oe}, 8'h01, "output back after pause");
      m.xfer(8'h00, 3, 4, rd);
      m.stop();
      check({hi[7:4], rd[3:0]}, 8'h44, "resumed byte");
   endtask

   task automatic s_idpage();
      m.mode3 = 1'b0;
      wr_any(OP_WRID, 8'h00, 8'h03, {8'h9e});
      wait_idle();
      // Address-high bit two asks for the lock along with the data
      wr_any(OP_WRID, 8'h04, 8'h04, {8'h6b});
      wait_idle();
      wr_any(OP_WRID, 8'h00, 8'h03, {8'h00});
      wait_idle();
      status(8'h02);
      rd_any(OP_RDID, 8'h00, 8'h03, {8'h9e, 8'h6b});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      miscompares = 0;
      n_compared  = 0;
      reset       = 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      check({7'h0, standby}, 8'h01, "standby in reset");
      reset = 1'b0;
      m.tick(4);
      check({7'h0, so_oe}, 8'h00, "output off after reset");
      s_status();
      s_write();
      s_protect();
      s_misalign();
      s_pause();
      s_idpage();
      conclude();
   end
endmodule
